// [rtl/flash_host_consts.svh]
// timing counts and command constants for the parallel flash host controller
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define RESET_LOW_PULSE_NS 100
`define RESET_LOW_PULSE_CYC ((`RESET_LOW_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_TO_WRITE_NS 1000
`define RESET_TO_WRITE_CYC ((`RESET_TO_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_TO_OUTPUT_NS 400
`define RESET_TO_OUTPUT_CYC ((`RESET_TO_OUTPUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_NS 90
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS 50
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC 1
`define HOLD_CYC 1
`define CMD_READ_ARRAY 8'hFF
`endif

// [rtl/flash_host_pkg.sv]
// types shared by the parallel flash host controller
package flash_host_pkg;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RESET} op_t;
  typedef struct packed {
    logic [1:0] op;
    logic [23:0] addr;
    logic [15:0] data;
  } request_t;
  typedef struct packed {
    logic selectANotReg;
    logic selectBNotReg;
    logic outputEnableN;
    logic writeEnableN;
    logic resetPowerdownN;
    logic byteWide;
  } pins_t;
endpackage : flash_host_pkg

// [rtl/pin_sync.sv]
// three-stage synchroniser; output changes once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  initial
  begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be positive");
  end
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_t;
  sync_state_t state_reg;
  sync_state_t state_next;
  always_comb
  begin
    state_next = state_reg;
    state_next.s1 = pinIn;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (state_reg.s2[i] == state_reg.s3[i]) state_next.out[i] = state_reg.s3[i];
    end
  end
  always_ff @(posedge clock)
  begin
    if (!nrst) state_reg <= '{default: '1};
    else state_reg <= state_next;
  end
  assign syncOut = state_reg.out;
endmodule : pin_sync

// [rtl/flash_host_ctrl.sv]
// host-side bus controller driving an asynchronous parallel flash through its pins
`include "flash_host_consts.svh"
module flash_host_ctrl #(
  parameter int ADDR_WIDTH = 24,
  parameter int ACCESS_CYCLES = `ACCESS_CYC,
  parameter int WRITE_PULSE_CYCLES = `WRITE_PULSE_CYC,
  parameter int RESET_LOW_CYCLES = `RESET_LOW_PULSE_CYC,
  parameter int RESET_RECOVERY_CYCLES = `RESET_TO_WRITE_CYC,
  parameter int OUTPUT_WAKE_CYCLES = `RESET_TO_OUTPUT_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic reqValid,
  output logic reqReady,
  input wire flash_host_pkg::request_t req,
  input wire logic byteMode,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic busy,
  output logic deviceBusy,
  output logic [ADDR_WIDTH-1:0] flashAddr,
  output logic [15:0] dqOut,
  output logic dqOe,
  input wire logic [15:0] dqIn,
  output logic select_a_n,
  output logic select_b_n,
  output logic outputEnableN,
  output logic writeEnableN,
  output logic reset_powerdown_n,
  output logic byteWideN,
  input wire logic ready_busy_n
);
  initial
  begin
    if (ADDR_WIDTH < 1 || ADDR_WIDTH > 24) $error("flash_host_ctrl: ADDR_WIDTH out of range");
    // the data synchroniser needs two access cycles of margin before the sample
    if (ACCESS_CYCLES < 2 || WRITE_PULSE_CYCLES < 1) $error("flash_host_ctrl: bad timing");
    if (RESET_RECOVERY_CYCLES < OUTPUT_WAKE_CYCLES) $error("flash_host_ctrl: bad recovery");
  end
  typedef enum logic [2:0] {ST_RESET, ST_RECOVER, ST_IDLE, ST_RD_WAIT, ST_RD_END,
                            ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD} phase_t;
  typedef struct packed {
    phase_t phase;
    logic [15:0] count;
    logic [ADDR_WIDTH-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic wideBus;
    flash_host_pkg::pins_t pins;
    logic driveDq;
  } ctrl_state_t;
  ctrl_state_t state_reg;
  ctrl_state_t state_next;
  logic rdyBusySync;
  logic [15:0] dqSync;
  logic [15:0] lowLaneMask;
  // status pin is open drain from the device; synchronise before use
  pin_sync #(.WIDTH(1)) uStsSync (
    .clock(clock),
    .nrst(nrst),
    .pinIn(ready_busy_n),
    .syncOut(rdyBusySync)
  );
  // data pins come from the device as well; the access window absorbs the sync delay
  pin_sync #(.WIDTH(16)) uDqSync (
    .clock(clock),
    .nrst(nrst),
    .pinIn(dqIn),
    .syncOut(dqSync)
  );
  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    lowLaneMask = state_reg.wideBus ? 16'hFFFF : 16'h00FF;
    unique case (state_reg.phase)
      ST_RESET:
      begin
        // hold reset low with everything idle; device aborts any algorithm
        state_next.pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, state_reg.wideBus};
        state_next.driveDq = 1'b0;
        if (state_reg.count >= 16'(RESET_LOW_CYCLES - 1))
        begin
          state_next.phase = ST_RECOVER;
          state_next.count = '0;
          state_next.pins.resetPowerdownN = 1'b1;
        end
        else state_next.count = state_reg.count + 16'h0001;
      end
      ST_RECOVER:
      begin
        // no access until recovery elapsed and device reports ready
        if (state_reg.count >= 16'(RESET_RECOVERY_CYCLES - 1) && rdyBusySync)
        begin
          state_next.phase = ST_IDLE;
          state_next.count = '0;
        end
        else if (state_reg.count < 16'hFFFF) state_next.count = state_reg.count + 16'h0001;
      end
      ST_IDLE:
      begin
        state_next.count = '0;
        if (reqValid)
        begin
          state_next.addr = req.addr[ADDR_WIDTH-1:0];
          state_next.wdata = req.data & lowLaneMask;
          unique case (req.op)
            2'(flash_host_pkg::OP_RESET):
            begin
              state_next.phase = ST_RESET;
              state_next.pins.resetPowerdownN = 1'b0;
            end
            2'(flash_host_pkg::OP_WRITE):
            begin
              // WE stays high for setup; OE high first so the two never overlap
              state_next.phase = ST_WR_SETUP;
              state_next.pins.outputEnableN = 1'b1;
              state_next.pins.selectANotReg = 1'b0;
              state_next.pins.selectBNotReg = 1'b0;
              state_next.driveDq = 1'b1;
            end
            default:
            begin
              // read of whatever mode was last selected by command
              state_next.phase = ST_RD_WAIT;
              state_next.pins.writeEnableN = 1'b1;
              state_next.pins.selectANotReg = 1'b0;
              state_next.pins.selectBNotReg = 1'b0;
              state_next.pins.outputEnableN = 1'b0;
              state_next.driveDq = 1'b0;
            end
          endcase
        end
        // width only changes while idle, never inside a bus cycle
        else state_next.wideBus = !byteMode;
      end
      ST_RD_WAIT:
      begin
        if (state_reg.count >= 16'(ACCESS_CYCLES + 3))
        begin
          state_next.rdata = dqSync & lowLaneMask;
          state_next.rvalid = 1'b1;
          state_next.phase = ST_RD_END;
          state_next.pins.outputEnableN = 1'b1;
          state_next.pins.selectANotReg = 1'b1;
          state_next.pins.selectBNotReg = 1'b1;
        end
        else state_next.count = state_reg.count + 16'h0001;
      end
      ST_RD_END:
      begin
        state_next.phase = ST_IDLE;
      end
      ST_WR_SETUP:
      begin
        state_next.phase = ST_WR_PULSE;
        state_next.count = '0;
        state_next.pins.writeEnableN = 1'b0;
      end
      ST_WR_PULSE:
      begin
        if (state_reg.count >= 16'(WRITE_PULSE_CYCLES - 1))
        begin
          // WE rises first so the device latches address and data there
          state_next.pins.writeEnableN = 1'b1;
          state_next.phase = ST_WR_HOLD;
        end
        else state_next.count = state_reg.count + 16'h0001;
      end
      ST_WR_HOLD:
      begin
        state_next.pins.selectANotReg = 1'b1;
        state_next.pins.selectBNotReg = 1'b1;
        state_next.driveDq = 1'b0;
        state_next.phase = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state_reg <= '0;
      state_reg.phase <= ST_RESET;
      state_reg.pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      state_reg.wideBus <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end
  assign reqReady = (state_reg.phase == ST_IDLE);
  assign rspValid = state_reg.rvalid;
  assign rspData = state_reg.rdata;
  assign busy = (state_reg.phase != ST_IDLE);
  assign deviceBusy = !rdyBusySync;
  assign flashAddr = state_reg.addr;
  assign dqOut = state_reg.wdata;
  assign dqOe = state_reg.driveDq;
  assign select_a_n = state_reg.pins.selectANotReg;
  assign select_b_n = state_reg.pins.selectBNotReg;
  assign outputEnableN = state_reg.pins.outputEnableN;
  assign writeEnableN = state_reg.pins.writeEnableN;
  assign reset_powerdown_n = state_reg.pins.resetPowerdownN;
  assign byteWideN = state_reg.wideBus;
endmodule : flash_host_ctrl

// [testbench/flash_host_ctrl_chk.sv]
// pin sequencing checker for the flash host controller
module flash_host_ctrl_chk #(
  parameter int ACCESS_CYCLES = 3
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire flash_host_pkg::request_t req,
  input wire logic rspValid,
  input wire logic dqOe,
  input wire logic select_a_n,
  input wire logic select_b_n,
  input wire logic outputEnableN,
  input wire logic writeEnableN,
  input wire logic reset_powerdown_n
);
  localparam int RD_LAT = ACCESS_CYCLES + 5;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence readTake;
    reqValid && reqReady && req.op == 2'd0;
  endsequence
  sequence weLowSeq;
    !writeEnableN [*2] ##1 writeEnableN;
  endsequence
  oe_we_excl_a: assert property (outputEnableN || writeEnableN) else $error("oe with we");
  read_gate_a: assert property (!outputEnableN |-> !select_a_n && !select_b_n
    && reset_powerdown_n && !dqOe) else $error("read gating");
  write_gate_a: assert property (!writeEnableN |-> !select_a_n && !select_b_n
    && outputEnableN && dqOe) else $error("write gating");
  read_latency_a: assert property (readTake |-> ##RD_LAT rspValid) else $error("read late");
  we_pulse_a: assert property ($fell(writeEnableN) |-> weLowSeq) else $error("we pulse");
  reset_hold_a:
    assert property ($fell(reset_powerdown_n) |-> !reset_powerdown_n [*3]) else $error("rp short");
  recovery_gap_a:
    assert property ($rose(reset_powerdown_n) |-> writeEnableN [*4]) else $error("write early");
  reset_follow_a:
    assert property (disable iff (1'b0) !nrst |=> !reset_powerdown_n) else $error("rp high");
endmodule : flash_host_ctrl_chk

bind flash_host_ctrl flash_host_ctrl_chk #(.ACCESS_CYCLES(ACCESS_CYCLES)) u_chk (
  .clock(clock), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady), .req(req),
  .rspValid(rspValid), .dqOe(dqOe), .select_a_n(select_a_n), .select_b_n(select_b_n),
  .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
  .reset_powerdown_n(reset_powerdown_n));

// [testbench/flash_device_model.sv]
// behavioural parallel flash answering the controller's pin cycles
module flash_device_model #(
  parameter logic [15:0] MAKER_CODE = 16'h005A, // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h00A7, // arbitrary value
  parameter bit SUPPLY_LOCKED = 1'b0
) (
  input wire logic select_a_n,
  input wire logic select_b_n,
  input wire logic outputEnableN,
  input wire logic writeEnableN,
  input wire logic reset_powerdown_n,
  input wire logic byteWideN,
  input wire logic [23:0] flashAddr,
  input wire logic [15:0] dqOut,
  output logic [15:0] dqIn,
  output logic ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [15:0] lastOut = 16'h0000;
  logic [15:0] word, pendD;
  logic [7:0] pendA;
  logic [1:0] mode = 2'd0;
  logic setup = 1'b0;
  logic wsmBusy = 1'b0;
  logic aborting = 1'b0;
  wire sel = !select_a_n && !select_b_n;
  wire wr = sel && !writeEnableN && outputEnableN && reset_powerdown_n;
  wire rd = sel && !outputEnableN && writeEnableN && reset_powerdown_n;
  initial
    for (int i = 0; i < 256; i++)
      mem[i] = {8'(i), 8'(i)} ^ 16'h5A3C;
  always_comb
    case (mode)
      2'd0: word = mem[flashAddr[7:0]];
      2'd1: word = flashAddr[0] ? DEVICE_CODE : MAKER_CODE;
      2'd2: word = {8'h00, !wsmBusy, 7'h00};
      default: word = 16'h0051;
    endcase
  // released pins show the inverse of the last value so a stale sample cannot pass
  assign dqIn = rd ? (byteWideN ? word : {~word[15:8], word[7:0]}) : ~lastOut;
  assign ready_busy_n = !(wsmBusy || aborting);
  always @(negedge rd)
    lastOut = word;
  always @(negedge wr)
  begin
    if (reset_powerdown_n && setup)
    begin
      setup = 1'b0;
      if (!SUPPLY_LOCKED && !wsmBusy)
      begin
        pendA = flashAddr[7:0];
        pendD = dqOut;
        wsmBusy = 1'b1;
      end
    end
    else if (reset_powerdown_n)
      case (dqOut[7:0])
        8'hFF: mode = 2'd0;
        8'h90: mode = 2'd1;
        8'h70: mode = 2'd2;
        8'h98: mode = 2'd3;
        8'h40, 8'h10: setup = 1'b1;
        default: ;
      endcase
  end
  always @(posedge wsmBusy)
  begin
    #400;
    if (wsmBusy)
    begin
      mem[pendA] = pendD;
      wsmBusy = 1'b0;
    end
  end
  always @(negedge reset_powerdown_n)
  begin
    wsmBusy = 1'b0;
    setup = 1'b0;
    mode = 2'd0;
    aborting = 1'b1;
    #100 aborting = 1'b0;
  end
endmodule : flash_device_model

// [testbench/flash_bus_mode_control_test.sv]
// self-checking bench for the flash host controller against a behavioural flash
module flash_bus_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic reqValid = 1'b0;
  logic byteMode = 1'b0;
  flash_host_pkg::request_t req = '0;
  logic reqReady, rspValid, busy, deviceBusy, dqOe, selA, selB, oeN, weN, rpN, bwN, rbN;
  logic [15:0] rspData, dqOut, dqIn;
  logic [23:0] flashAddr;
  logic [15:0] expQ[$];
  logic [31:0] seed = 32'hEAE1A2DC;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  flash_host_ctrl #(.ACCESS_CYCLES(3), .WRITE_PULSE_CYCLES(2), .RESET_LOW_CYCLES(3),
    .RESET_RECOVERY_CYCLES(4), .OUTPUT_WAKE_CYCLES(2)) u_dut (.clock(clock), .nrst(nrst),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .byteMode(byteMode),
    .rspValid(rspValid), .rspData(rspData), .busy(busy), .deviceBusy(deviceBusy),
    .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .select_a_n(selA),
    .select_b_n(selB), .outputEnableN(oeN), .writeEnableN(weN), .reset_powerdown_n(rpN),
    .byteWideN(bwN), .ready_busy_n(rbN));
  flash_device_model u_flash (.select_a_n(selA), .select_b_n(selB), .outputEnableN(oeN),
    .writeEnableN(weN), .reset_powerdown_n(rpN), .byteWideN(bwN), .flashAddr(flashAddr),
    .dqOut(dqOut), .dqIn(dqIn), .ready_busy_n(rbN));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  function automatic logic [15:0] initWord(input logic [7:0] a);
    return {a, a} ^ 16'h5A3C;
  endfunction : initWord
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // requests are raised 1 ns after an edge and dropped right after the taking edge
  task automatic issue(input logic [1:0] op, input logic [23:0] a, input logic [15:0] d);
    for (int n = 0; n < 3000 && reqReady !== 1'b1; n++)
      tick(1);
    req = '{op: op, addr: a, data: d};
    reqValid = 1'b1;
    tick(1);
    reqValid = 1'b0;
  endtask : issue
  task automatic rd(input logic [23:0] a, input logic [15:0] e);
    expQ.push_back(e);
    issue(2'd0, a, 16'h0000);
  endtask : rd
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      miscompares++;
      summarize();
    end
    else if (rspValid === 1'b1)
      check(rspData, expQ.size() > 0 ? expQ.pop_front() : 16'hXXXX);
  end
  initial
  begin
    logic [7:0] a;
    logic [15:0] d;
    tick(6);
    nrst = 1'b1;
    seed = lfsr(seed);
    a = seed[7:0] | 8'h80;
    d = {seed[31:24], 8'h3C};
    rd(24'(a), initWord(a));
    issue(2'd1, 24'(a), d);
    rd(24'(a), initWord(a));
    issue(2'd1, 24'h0, 16'h0090);
    rd(24'h0, 16'h005A);
    rd(24'h1, 16'h00A7);
    issue(2'd1, 24'h0, 16'h0098);
    rd(24'h10, 16'h0051);
    issue(2'd1, 24'h0, 16'h0040);
    issue(2'd1, 24'(a), d);
    tick(8);
    check(16'(deviceBusy), 16'h0001);
    issue(2'd1, 24'h0, 16'h0070);
    rd(24'h0, 16'h0000);
    for (int i = 0; i < 200 && deviceBusy !== 1'b0; i++)
      tick(1);
    rd(24'h0, 16'h0080);
    issue(2'd1, 24'h0, 16'h00FF);
    rd(24'(a), d);
    issue(2'd1, 24'h0, 16'h0040);
    issue(2'd1, 24'h5, 16'h1111);
    tick(6);
    issue(2'd2, 24'h0, 16'h0000);
    rd(24'h5, initWord(8'h05));
    issue(2'd1, 24'h0, 16'h0070);
    rd(24'h0, 16'h0080);
    issue(2'd1, 24'h0, 16'h00FF);
    byteMode = 1'b1;
    // width is taken only in an idle cycle without a request, so let the write finish
    tick(8);
    rd(24'h7, initWord(8'h07) & 16'h00FF);
    tick(20);
    summarize();
  end
endmodule : flash_bus_mode_control_test
